// [swc_wake_cfg.sv]
// What this block does
// - Wakeup timer starts automatically on stop entry when wake enable set.
// - Wakeup counter restarts from zero on each stop entry.
// - Unmasked pending keyboard or wakeup request ends stop mode.
// - Port A read shows read-only wake latch, no direction or pullup.
// - Upper four bits of keyboard status register read zero.
// - Pending flag set by keyboard or wakeup request, cleared by reset.
// - Writing one to acknowledge clears requests; bit reads zero.
// - Mask bit set blocks keyboard and wakeup CPU interrupts.
// - Wake enable clear means no wakeup request is latched.
// - Each option register takes one write per reset, always readable.
// - Option registers decode at indices 1E and 1F.
// - In stop, period select picks 512 or 16384 oscillator cycles.
// - Outside stop, period select picks 8176 or 262128 watchdog cycles.
// - Reset pin enable and supply mode cleared by power-on reset only.
// - Short recovery gives 32-cycle stop exit, else 4096 cycles.
// - Stop exit by low-voltage reset always uses long recovery.
// - Stop enable clear makes stop an illegal opcode.
// - Watchdog disable bit set turns the watchdog off.
// - Monitor runs in stop only if in-stop set and power on.
// - Option bits drive monitor reset, power and supply mode outputs.
// - Two-bit oscillator select picks internal, external, RC or crystal.
// - Option bits drive interrupt pin, its pullup and reset pin.
// - Wake latch sits at bit 6 of port A data.
// - Wakeup counter idles outside stop mode; oscillator synchroniser runs in all modes.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
module swc_wake_cfg (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic wake_rc_osc,
  input wire logic kbd_key_req,
  input wire logic stop_req,
  input wire logic lvi_reset,
  output logic kbd_irq,
  output logic kbd_pending,
  output logic in_stop,
  output logic stop_recovering,
  output logic stop_illegal,
  output swc_pkg::swc_cfg_out_t cfg_out
);

  ////////////////////////////////////////////////////////////////////////////
  swc_pkg::swc_state_t st;
  swc_pkg::swc_state_t nxt;
  swc_pkg::swc_por_t por_st;
  logic [5:0] idx;
  logic req;
  logic wr_acc;
  logic cfg_two_wr;
  logic cfg_one_wr;
  logic osc_agree;
  logic osc_rise;
  logic [13:0] wake_last;
  logic wake_fire;
  logic pending;
  logic wake_exit;
  logic [12:0] rec_last;
  logic [7:0] rd_mux;

  assign idx = address[7:2];
  assign req = read | write;
  assign wr_acc = write & st.ack & byteenable[0];
  assign cfg_two_wr = wr_acc & (idx == swc_pkg::IDX_CFG_TWO) & ~st.cfg_two_done;
  assign cfg_one_wr = wr_acc & (idx == swc_pkg::IDX_CFG_ONE) & ~st.cfg_one_done;

  // Only the second and third stages are compared; the first may be metastable
  assign osc_agree = st.osc_sync[1] == st.osc_sync[2];
  assign osc_rise = osc_agree & st.osc_sync[2] & ~st.osc_level;

  assign wake_last = st.cfg_one[swc_pkg::PERIOD_SEL_BIT] ?
    14'(swc_pkg::WAKE_SHORT_CYC - 15'h0001) :
    14'(swc_pkg::WAKE_LONG_CYC - 15'h0001);

  assign wake_fire = (st.mode == swc_pkg::MODE_STOP) & st.wake_irq_enable &
    osc_rise & (st.wake_cnt == wake_last);

  assign pending = st.wake_latch | st.key_pend;
  assign wake_exit = pending & ~st.kbd_irq_mask;

  assign rec_last = (st.cfg_one[swc_pkg::SHORT_REC_BIT] & ~st.long_rec) ?
    (swc_pkg::REC_SHORT_CYC - 13'h0001) :
    (swc_pkg::REC_LONG_CYC - 13'h0001);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      swc_pkg::IDX_PORT_A: begin
        rd_mux[swc_pkg::WAKE_LATCH_BIT] = st.wake_latch;
      end
      swc_pkg::IDX_KBD_SC: begin
        rd_mux[swc_pkg::KBD_PEND_BIT] = pending;
        rd_mux[swc_pkg::KBD_MASK_BIT] = st.kbd_irq_mask;
      end
      swc_pkg::IDX_KBD_WE: begin
        rd_mux[swc_pkg::WAKE_IE_BIT] = st.wake_irq_enable;
      end
      swc_pkg::IDX_CFG_TWO: begin
        rd_mux = st.cfg_two;
        rd_mux[swc_pkg::RST_PIN_EN_BIT] = por_st.reset_pin_en;
      end
      swc_pkg::IDX_CFG_ONE: begin
        rd_mux = st.cfg_one;
        rd_mux[swc_pkg::LV_SUPPLY_BIT] = por_st.supply_mode;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt = st;
    nxt.osc_sync = {st.osc_sync[1:0], wake_rc_osc};
    if (osc_agree) begin
      nxt.osc_level = st.osc_sync[2];
    end
    nxt.stop_illegal = 1'b0;

    // One wait state per access; read data are captured before the answer
    nxt.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      nxt.rdata = read ? rd_mux : 8'h00;
    end

    if (wr_acc && idx == swc_pkg::IDX_KBD_SC) begin
      nxt.kbd_irq_mask = writedata[swc_pkg::KBD_MASK_BIT];
      if (writedata[swc_pkg::KBD_ACK_BIT]) begin
        nxt.key_pend = 1'b0;
        nxt.wake_latch = 1'b0;
      end
    end
    if (wr_acc && idx == swc_pkg::IDX_KBD_WE) begin
      nxt.wake_irq_enable = writedata[swc_pkg::WAKE_IE_BIT];
    end
    if (cfg_two_wr) begin
      nxt.cfg_two = writedata[7:0];
      nxt.cfg_two_done = 1'b1;
    end
    if (cfg_one_wr) begin
      nxt.cfg_one = writedata[7:0];
      nxt.cfg_one_done = 1'b1;
    end

    if (kbd_key_req) begin
      nxt.key_pend = 1'b1;
    end
    if (wake_fire) begin
      nxt.wake_latch = 1'b1;
    end

    case (st.mode)
      swc_pkg::MODE_RUN: begin
        nxt.wake_cnt = 14'h0000;
        nxt.rec_cnt = 13'h0000;
        nxt.long_rec = 1'b0;
        if (stop_req) begin
          if (st.cfg_one[swc_pkg::STOP_EN_BIT]) begin
            nxt.mode = swc_pkg::MODE_STOP;
            nxt.wake_cnt = 14'h0000;
          end else begin
            nxt.stop_illegal = 1'b1;
          end
        end
      end
      swc_pkg::MODE_STOP: begin
        if (st.wake_irq_enable && osc_rise) begin
          nxt.wake_cnt = wake_fire ? 14'h0000 : st.wake_cnt + 14'h0001;
        end
        if (lvi_reset) begin
          nxt.long_rec = 1'b1;
          nxt.mode = swc_pkg::MODE_RECOVER;
        end else if (wake_exit) begin
          nxt.mode = swc_pkg::MODE_RECOVER;
        end
      end
      swc_pkg::MODE_RECOVER: begin
        nxt.wake_cnt = 14'h0000;
        if (st.rec_cnt == rec_last) begin
          nxt.mode = swc_pkg::MODE_RUN;
          nxt.rec_cnt = 13'h0000;
        end else begin
          nxt.rec_cnt = st.rec_cnt + 13'h0001;
        end
      end
      default: begin
        nxt.mode = swc_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst or posedge por) begin
    if (rst || por) begin
      st <= swc_pkg::STATE_RST;
    end else begin
      st <= nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge por) begin
    if (por) begin
      por_st <= swc_pkg::POR_RST;
    end else if (cfg_two_wr) begin
      por_st.reset_pin_en <= writedata[swc_pkg::RST_PIN_EN_BIT];
    end else if (cfg_one_wr) begin
      por_st.supply_mode <= writedata[swc_pkg::LV_SUPPLY_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign readdata = {24'h000000, st.rdata};
  assign waitrequest = req & ~st.ack;
  assign kbd_pending = pending;
  assign kbd_irq = pending & ~st.kbd_irq_mask;
  assign in_stop = st.mode == swc_pkg::MODE_STOP;
  assign stop_recovering = st.mode == swc_pkg::MODE_RECOVER;
  assign stop_illegal = st.stop_illegal;

  always_comb begin
    cfg_out.wdog_enable = ~st.cfg_one[swc_pkg::WDOG_DIS_BIT];
    cfg_out.wdog_timeout = st.cfg_one[swc_pkg::PERIOD_SEL_BIT] ?
      swc_pkg::WDOG_SHORT_CYC : swc_pkg::WDOG_LONG_CYC;
    cfg_out.stop_enable = st.cfg_one[swc_pkg::STOP_EN_BIT];
    cfg_out.lowvolt_reset_disable = st.cfg_one[swc_pkg::LV_RST_DIS_BIT];
    cfg_out.lowvolt_power_disable = st.cfg_one[swc_pkg::LV_PWR_DIS_BIT];
    cfg_out.lowvolt_supply_mode = por_st.supply_mode;
    cfg_out.lowvolt_on = ~st.cfg_one[swc_pkg::LV_PWR_DIS_BIT] &
      (~in_stop | st.cfg_one[swc_pkg::LV_IN_STOP_BIT]);
    cfg_out.osc_select = {st.cfg_two[swc_pkg::OSC_SEL_HI_BIT],
      st.cfg_two[swc_pkg::OSC_SEL_LO_BIT]};
    cfg_out.int_pin_pull_disable = st.cfg_two[swc_pkg::INT_PULL_DIS_BIT];
    cfg_out.int_pin_function_enable = st.cfg_two[swc_pkg::INT_PIN_EN_BIT];
    cfg_out.reset_pin_function_enable = por_st.reset_pin_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || por);

  a_stop_entry_zero: assert property (
    $rose(in_stop) |-> st.wake_cnt == 14'h0000)
    else $error("wake counter not zero at stop entry");

  a_run_counter_idle: assert property (
    st.mode == swc_pkg::MODE_RUN |-> st.wake_cnt == 14'h0000)
    else $error("wake counter active outside stop");

  a_latch_needs_enable: assert property (
    $rose(st.wake_latch) |-> $past(st.wake_irq_enable) && $past(in_stop))
    else $error("wake latch set without enable");

  a_fire_sets_latch: assert property (
    wake_fire |=> st.wake_latch && kbd_pending)
    else $error("terminal count did not latch request");

  a_mask_blocks_irq: assert property (
    st.kbd_irq_mask |-> !kbd_irq)
    else $error("masked request reached interrupt");

  a_pending_wakes: assert property (
    in_stop && pending && !st.kbd_irq_mask |=> stop_recovering)
    else $error("unmasked request did not end stop");

  a_cfg_write_once: assert property (
    write && st.ack && st.cfg_one_done && idx == swc_pkg::IDX_CFG_ONE
    |=> $stable(st.cfg_one))
    else $error("option register rewritten");

  a_stop_illegal: assert property (
    st.mode == swc_pkg::MODE_RUN && stop_req && !cfg_out.stop_enable
    |=> stop_illegal && st.mode == swc_pkg::MODE_RUN)
    else $error("disabled stop not flagged illegal");

  a_short_recovery: assert property (
    $rose(stop_recovering) && st.cfg_one[swc_pkg::SHORT_REC_BIT] &&
    !st.long_rec |-> stop_recovering [*8] ##24 stop_recovering ##1 !stop_recovering)
    else $error("short recovery not 32 cycles");

  a_ack_clears: assert property (
    wr_acc && idx == swc_pkg::IDX_KBD_SC &&
    writedata[swc_pkg::KBD_ACK_BIT] && !kbd_key_req && !wake_fire
    |=> !kbd_pending)
    else $error("acknowledge did not clear pending");

  a_kbsc_upper_zero: assert property (
    read && st.ack && idx == swc_pkg::IDX_KBD_SC |-> readdata[7:4] == 4'h0)
    else $error("status upper bits not zero");

  a_ack_reads_zero: assert property (
    read && st.ack && idx == swc_pkg::IDX_KBD_SC |->
    readdata[swc_pkg::KBD_ACK_BIT] == 1'b0)
    else $error("acknowledge bit read back as one");

  // Read data were captured one edge before the answer
  a_port_a_latch: assert property (
    read && st.ack && idx == swc_pkg::IDX_PORT_A |->
    readdata[swc_pkg::WAKE_LATCH_BIT] == $past(st.wake_latch))
    else $error("port A wake bit differs from latch");

  a_fire_needs_stop: assert property (
    !in_stop |-> !wake_fire)
    else $error("wake counter fired outside stop");

  c_stop_entry: cover property ($rose(in_stop));
  c_illegal_stop: cover property (stop_illegal);
  c_wake_fire: cover property (wake_fire ##1 st.wake_latch);
  c_back_to_run: cover property ($fell(stop_recovering));

endmodule : swc_wake_cfg

// [swc_pkg.sv]
package swc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PORT_A = 6'h00;
  localparam logic [5:0] IDX_KBD_SC = 6'h1A;
  localparam logic [5:0] IDX_KBD_WE = 6'h1B;
  localparam logic [5:0] IDX_CFG_TWO = 6'h1E;
  localparam logic [5:0] IDX_CFG_ONE = 6'h1F;

  // port_a_data
  localparam int WAKE_LATCH_BIT = 6;
  // kbd_status_control
  localparam int KBD_PEND_BIT = 3;
  localparam int KBD_ACK_BIT = 2;
  localparam int KBD_MASK_BIT = 1;
  // kbd_wake_enable
  localparam int WAKE_IE_BIT = 6;
  // chip_options_two
  localparam int INT_PULL_DIS_BIT = 7;
  localparam int INT_PIN_EN_BIT = 6;
  localparam int OSC_SEL_HI_BIT = 4;
  localparam int OSC_SEL_LO_BIT = 3;
  localparam int RST_PIN_EN_BIT = 1;
  // chip_options_one
  localparam int PERIOD_SEL_BIT = 7;
  localparam int LV_IN_STOP_BIT = 6;
  localparam int LV_RST_DIS_BIT = 5;
  localparam int LV_PWR_DIS_BIT = 4;
  localparam int LV_SUPPLY_BIT = 3;
  localparam int SHORT_REC_BIT = 2;
  localparam int STOP_EN_BIT = 1;
  localparam int WDOG_DIS_BIT = 0;

  // Timing counts
  localparam logic [14:0] WAKE_SHORT_CYC = 15'h0200;
  localparam logic [14:0] WAKE_LONG_CYC = 15'h4000;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
  localparam logic [12:0] REC_LONG_CYC = 13'h1000;
  localparam logic [17:0] WDOG_SHORT_CYC = 18'h01FF0;
  localparam logic [17:0] WDOG_LONG_CYC = 18'h3FFF0;

  typedef enum logic [1:0] {
    MODE_RUN = 2'h0,
    MODE_STOP = 2'h1,
    MODE_RECOVER = 2'h3
  } swc_mode_t;

  typedef struct packed {
    swc_mode_t mode;
    logic [13:0] wake_cnt;
    logic [12:0] rec_cnt;
    logic long_rec;
    logic [2:0] osc_sync;
    logic osc_level;
    logic wake_latch;
    logic key_pend;
    logic kbd_irq_mask;
    logic wake_irq_enable;
    logic cfg_two_done;
    logic cfg_one_done;
    logic [7:0] cfg_two;
    logic [7:0] cfg_one;
    logic ack;
    logic [7:0] rdata;
    logic stop_illegal;
  } swc_state_t;

  typedef struct packed {
    logic reset_pin_en;
    logic supply_mode;
  } swc_por_t;

  typedef struct packed {
    logic wdog_enable;
    logic [17:0] wdog_timeout;
    logic stop_enable;
    logic lowvolt_reset_disable;
    logic lowvolt_power_disable;
    logic lowvolt_supply_mode;
    logic lowvolt_on;
    logic [1:0] osc_select;
    logic int_pin_pull_disable;
    logic int_pin_function_enable;
    logic reset_pin_function_enable;
  } swc_cfg_out_t;

  localparam swc_state_t STATE_RST = '0;
  localparam swc_por_t POR_RST = '0;

endpackage : swc_pkg

// [tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, rst, por, read, write, wake_rc_osc, kbd_key_req;
  logic stop_req, lvi_reset, waitrequest, kbd_irq, kbd_pending, in_stop;
  logic stop_recovering, stop_illegal;
  logic [7:0] address, rd;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  swc_pkg::swc_cfg_out_t cfg_out;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  swc_wake_cfg dut (
    .clk_sys(clk_sys), .rst(rst), .por(por), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .wake_rc_osc(wake_rc_osc),
    .kbd_key_req(kbd_key_req), .stop_req(stop_req),
    .lvi_reset(lvi_reset), .kbd_irq(kbd_irq), .kbd_pending(kbd_pending),
    .in_stop(in_stop), .stop_recovering(stop_recovering),
    .stop_illegal(stop_illegal), .cfg_out(cfg_out)
  );

  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Request held until an edge sees waitrequest low; data taken there
  // Ends mid-cycle so the caller compares settled outputs
  task automatic bus(input logic rw, input logic [5:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= {idx, 2'h0};
    writedata <= {24'h000000, d};
    read <= !rw;
    write <= rw;
    @(posedge clk_sys);
    while (waitrequest !== 1'h0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n < 20, 1'h1, "bus answer");
    rd = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
    @(negedge clk_sys);
  endtask : bus

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk(rd, exp, "register read");
  endtask : rchk

  // Ends on a falling edge so the caller can look at one-cycle outputs
  task automatic pulse(input int s);
    @(posedge clk_sys);
    if (s == 0) stop_req <= 1'h1;
    if (s == 1) kbd_key_req <= 1'h1;
    if (s == 2) lvi_reset <= 1'h1;
    @(posedge clk_sys);
    stop_req <= 1'h0;
    kbd_key_req <= 1'h0;
    lvi_reset <= 1'h0;
    @(negedge clk_sys);
  endtask : pulse

  task automatic do_reset(input logic p);
    @(posedge clk_sys);
    rst <= 1'h1;
    por <= p;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    por <= 1'h0;
    @(posedge clk_sys);
  endtask : do_reset

  // Phases of four clocks keep each level above the synchroniser minimum
  task automatic osc_rises(input int n);
    repeat (n) begin
      wake_rc_osc <= 1'h1;
      repeat (4) @(posedge clk_sys);
      wake_rc_osc <= 1'h0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : osc_rises

  task automatic rec_len(input int exp);
    int n, w;
    n = 0;
    w = 0;
    while (stop_recovering !== 1'h1 && w < 30) begin
      @(negedge clk_sys);
      w++;
    end
    while (stop_recovering === 1'h1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, exp, "recovery length");
    chk(in_stop, 1'h0, "stop not left");
    @(posedge clk_sys);
  endtask : rec_len

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 60000) begin
      fails++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    por = 1'h1;
    read = 1'h0;
    write = 1'h0;
    address = 8'h00;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    wake_rc_osc = 1'h0;
    kbd_key_req = 1'h0;
    stop_req = 1'h0;
    lvi_reset = 1'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    por <= 1'h0;
    @(posedge clk_sys);
    rchk(swc_pkg::IDX_PORT_A, 8'h00);
    rchk(swc_pkg::IDX_KBD_SC, 8'h00);
    rchk(swc_pkg::IDX_CFG_ONE, 8'h00);
    rchk(6'h05, 8'h00);
    chk(cfg_out.wdog_timeout, swc_pkg::WDOG_LONG_CYC, "wdog long");
    chk(cfg_out.wdog_enable, 1'h1, "wdog on");
    chk(cfg_out.lowvolt_on, 1'h1, "monitor on");
    pulse(0);
    chk(stop_illegal, 1'h1, "illegal stop");
    chk(in_stop, 1'h0, "stop while disabled");
    @(posedge clk_sys);
    byteenable <= 4'hE;
    bus(1'h1, swc_pkg::IDX_KBD_WE, 8'h40);
    @(posedge clk_sys);
    byteenable <= 4'hF;
    rchk(swc_pkg::IDX_KBD_WE, 8'h00);
    bus(1'h1, swc_pkg::IDX_CFG_TWO, 8'hDA);
    bus(1'h1, swc_pkg::IDX_CFG_TWO, 8'h00);
    rchk(swc_pkg::IDX_CFG_TWO, 8'hDA);
    chk(cfg_out.int_pin_pull_disable, 1'h1, "pull off");
    chk(cfg_out.int_pin_function_enable, 1'h1, "int pin");
    chk(cfg_out.reset_pin_function_enable, 1'h1, "reset pin");
    bus(1'h1, swc_pkg::IDX_CFG_ONE, 8'h9E);
    bus(1'h1, swc_pkg::IDX_CFG_ONE, 8'h21);
    rchk(swc_pkg::IDX_CFG_ONE, 8'h9E);
    chk(cfg_out.wdog_timeout, swc_pkg::WDOG_SHORT_CYC, "wdog short");
    chk(cfg_out.lowvolt_power_disable, 1'h1, "power off");
    chk(cfg_out.lowvolt_on, 1'h0, "monitor off");
    chk(cfg_out.lowvolt_supply_mode, 1'h1, "supply mode");
    chk(cfg_out.stop_enable, 1'h1, "stop enable");
    do_reset(1'h0);
    chk(cfg_out.lowvolt_supply_mode, 1'h1, "supply kept");
    chk(cfg_out.reset_pin_function_enable, 1'h1, "pin kept");
    do_reset(1'h1);
    chk(cfg_out.lowvolt_supply_mode, 1'h0, "supply por");
    chk(cfg_out.reset_pin_function_enable, 1'h0, "pin por");
    for (int i = 0; i < 4; i++) begin
      do_reset(1'h0);
      bus(1'h1, swc_pkg::IDX_CFG_TWO, {3'h0, i[1:0], 3'h0});
      bus(1'h1, swc_pkg::IDX_CFG_ONE, {7'h00, i[0]});
      chk(cfg_out.osc_select, i[1:0], "osc select");
      chk(cfg_out.wdog_enable, !i[0], "wdog disable");
    end
    // Short wake period with short recovery, and one low-voltage exit with long recovery
    do_reset(1'h0);
    bus(1'h1, swc_pkg::IDX_CFG_ONE, 8'h86);
    bus(1'h1, swc_pkg::IDX_KBD_WE, 8'h40);
    rchk(swc_pkg::IDX_KBD_WE, 8'h40);
    for (int k = 0; k < 3; k++) begin
      pulse(0);
      chk(in_stop, 1'h1, "stop entry");
      chk(cfg_out.lowvolt_on, 1'h0, "monitor in stop");
      @(posedge clk_sys);
      if (k == 1) begin
        osc_rises(300);
        pulse(2);
        rec_len(4096);
      end else begin
        osc_rises(511);
        chk(kbd_pending, 1'h0, "early wake");
        wake_rc_osc <= 1'h1;
        rec_len(32);
        wake_rc_osc <= 1'h0;
        chk(kbd_irq, 1'h1, "wake irq");
        rchk(swc_pkg::IDX_PORT_A, 8'h40);
        rchk(swc_pkg::IDX_KBD_SC, 8'h08);
        bus(1'h1, swc_pkg::IDX_KBD_SC, 8'h04);
        rchk(swc_pkg::IDX_KBD_SC, 8'h00);
        rchk(swc_pkg::IDX_PORT_A, 8'h00);
      end
    end
    // Masked and disabled requests must not end stop
    bus(1'h1, swc_pkg::IDX_KBD_SC, 8'h02);
    bus(1'h1, swc_pkg::IDX_KBD_WE, 8'h00);
    pulse(1);
    chk(kbd_pending, 1'h1, "key pending");
    chk(kbd_irq, 1'h0, "masked irq");
    @(posedge clk_sys);
    rchk(swc_pkg::IDX_KBD_SC, 8'h0A);
    pulse(0);
    @(posedge clk_sys);
    osc_rises(512);
    chk(in_stop, 1'h1, "masked exit");
    rchk(swc_pkg::IDX_PORT_A, 8'h00);
    bus(1'h1, swc_pkg::IDX_KBD_SC, 8'h00);
    repeat (50) @(posedge clk_sys);
    chk(in_stop, 1'h0, "unmasked exit");
    chk(kbd_irq, 1'h1, "unmasked irq");
    summarize();
  end

endmodule : tb_top
